// ### dee_core.sv
// data eeprom sequencer: registers, page buffer, timed cycles, array
//
// Functional notes
// - page reads span up to 16 bytes
// - read end: load byte, step address in page mode, clear go
// - next read needs only go again
// - read go ignored without read allow
// - page bits fixed, only low nibble steps
// - low nibble saturates at 0FH
// - page buffer cleared by reset
// - wipe allow falling clears page buffer
// - program allow falling clears page buffer
// - page wipe: value write tags, steps nibble
// - wipe needs allow then go next write
// - wipe end clears go, then allow
// - wiped bytes read back zero
// - wipe and program cycles self timed
// - program needs allow then go next write
// - program go ignored without allow
// - program end clears go, then allow
// - byte program erases byte first
// - page program: value writes fill buffer
// - writes after nibble stopped are discarded
// - mode bit 4, 0 byte, 1 page
// - cycle time select picks durations
// - 2048 bytes, 11-bit address
// - done flag set at end, software clears
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module dee_core
   import dee_pkg::*;
#(
   parameter int unsigned WIPE0_CYC = DEE_WIPE0_CYC,
   parameter int unsigned WIPE1_CYC = DEE_WIPE1_CYC,
   parameter int unsigned BYTE0_CYC = DEE_BYTE0_CYC,
   parameter int unsigned BYTE1_CYC = DEE_BYTE1_CYC,
   parameter int unsigned PAGE0_CYC = DEE_PAGE0_CYC,
   parameter int unsigned PAGE1_CYC = DEE_PAGE1_CYC
) (
   input  wire logic       mclk_i,
   input  wire logic       rst_b_i,
   input  wire logic [2:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   output logic            busy_o,
   output logic            done_flag_o,
   output logic            done_irq_allow_o
);

   dee_bus_t            bus;          // bundled request
   dee_ctrl_t           wctl;         // write data seen as control
   dee_ctrl_t           ctrl_q;       // control register
   dee_state_t          state_q;      // sequencer state
   dee_state_t          state_d;
   logic [DEE_CW-1:0]   cnt_q;        // cycle timer
   logic [DEE_CW-1:0]   dur;          // timer load value
   logic                ld;           // timer load strobe
   logic [DEE_AW-1:0]   addr_q;       // index high and low
   logic [7:0]          val_q;        // value register
   logic [7:0]          mem_q [DEE_DEPTH];
   logic [7:0]          buf_q [DEE_PAGE];
   logic [DEE_PAGE-1:0] tag_q;        // per-byte tag of buffer
   logic                stop_q;       // nibble stopped at last byte
   logic                wa_p_q;       // wipe allow, last cycle
   logic                pa_p_q;       // program allow, last cycle
   logic                wipe_arm_q;   // allow seen, go may follow
   logic                prog_arm_q;
   logic                wr_lo;
   logic                wr_hi;
   logic                wr_val;
   logic                wr_ctl;
   logic                wr_done;
   logic                busy;
   logic                rd_end;       // read cycle ends this edge
   logic                wp_end;       // wipe cycle ends
   logic                pg_end;       // program cycle ends
   logic                val_load;     // page-mode value write taken
   logic                step;         // nibble step
   logic                clr_buf;      // buffer clear strobe
   logic [3:0]          nib_nxt;
   logic [7:0]          rd_byte;      // array byte at the index

   assign bus      = '{wr: wr_i, rd: rd_i, addr: addr_i, data: wdata_i};
   assign wctl     = dee_ctrl_t'(bus.data);
   assign busy     = (state_q != ST_IDLE);
   assign rd_end   = (state_q == ST_READ) && (cnt_q == '0);
   assign wp_end   = (state_q == ST_WIPE) && (cnt_q == '0);
   assign pg_end   = (state_q == ST_PROG) && (cnt_q == '0);
   assign rd_byte  = mem_q[addr_q];
   // any value write in page mode while idle is taken until the nibble has stopped
   assign val_load = wr_val && !busy && ctrl_q.mode && !stop_q;
   assign step     = ctrl_q.mode && (rd_end || val_load);
   // saturate rather than roll over to the first byte of the page
   assign nib_nxt  = (addr_q[3:0] == DEE_NIB_LAST) ? DEE_NIB_LAST
                                                    : addr_q[3:0] + 4'h1;
   assign clr_buf  = (wa_p_q && !ctrl_q.wipe_allow) ||
                     (pa_p_q && !ctrl_q.program_allow);

   // address decode of write strobes
   always_comb begin
      wr_lo   = 1'b0;
      wr_hi   = 1'b0;
      wr_val  = 1'b0;
      wr_ctl  = 1'b0;
      wr_done = 1'b0;
      if (bus.wr && bus.addr == DEE_OFF_LO) begin
         wr_lo = 1'b1;
      end else if (bus.wr && bus.addr == DEE_OFF_HI) begin
         wr_hi = 1'b1;
      end else if (bus.wr && bus.addr == DEE_OFF_VAL) begin
         wr_val = 1'b1;
      end else if (bus.wr && bus.addr == DEE_OFF_CTL) begin
         wr_ctl = 1'b1;
      end else if (bus.wr && bus.addr == DEE_OFF_DONE) begin
         wr_done = 1'b1;
      end
   end

   // next state and timer load
   always_comb begin
      state_d = state_q;
      ld      = 1'b0;
      dur     = '0;
      case (state_q)
         ST_IDLE: begin
            // the timer stands in for the free-running erase/write clock
            if (ctrl_q.wipe_go) begin
               state_d = ST_WIPE;
               ld      = 1'b1;
               dur     = ctrl_q.cts ? DEE_CW'(WIPE1_CYC - 1)
                                    : DEE_CW'(WIPE0_CYC - 1);
            end else if (ctrl_q.program_go) begin
               state_d = ST_PROG;
               ld      = 1'b1;
               if (ctrl_q.mode) begin
                  dur = ctrl_q.cts ? DEE_CW'(PAGE1_CYC - 1)
                                   : DEE_CW'(PAGE0_CYC - 1);
               end else begin
                  dur = ctrl_q.cts ? DEE_CW'(BYTE1_CYC - 1)
                                   : DEE_CW'(BYTE0_CYC - 1);
               end
            end else if (ctrl_q.read_go) begin
               state_d = ST_READ;
               ld      = 1'b1;
               dur     = DEE_CW'(DEE_READ_CYC - 1);
            end
         end
         ST_READ: begin
            if (cnt_q == '0) begin
               state_d = ST_IDLE;
            end
         end
         ST_WIPE: begin
            if (cnt_q == '0) begin
               state_d = ST_WFIN;
            end
         end
         ST_PROG: begin
            if (cnt_q == '0) begin
               state_d = ST_PFIN;
            end
         end
         // one extra cycle so allow drops after go
         ST_WFIN: state_d = ST_IDLE;
         ST_PFIN: state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   // state register and busy output
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= ST_IDLE;
         busy_o  <= 1'b0;
      end else begin
         state_q <= state_d;
         busy_o  <= (state_d != ST_IDLE);
      end
   end

   // cycle timer, counts down to zero
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q <= '0;
      end else if (ld) begin
         cnt_q <= dur;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - DEE_CW'(1);
      end
   end

   // two-write activation: allow arms, the very next write may start
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wipe_arm_q <= 1'b0;
         prog_arm_q <= 1'b0;
      end else if (bus.wr) begin
         wipe_arm_q <= wr_ctl && !busy && wctl.wipe_allow && !wctl.wipe_go;
         prog_arm_q <= wr_ctl && !busy && wctl.program_allow
                       && !wctl.program_go;
      end
   end

   // control register: software fields and hardware clears
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_q <= '0;
      end else if (wr_ctl && !busy) begin
         ctrl_q.cts           <= wctl.cts;
         ctrl_q.wipe_allow    <= wctl.wipe_allow;
         ctrl_q.mode          <= wctl.mode;
         ctrl_q.program_allow <= wctl.program_allow;
         ctrl_q.read_allow    <= wctl.read_allow;
         // go bits only stick when the arming write came just before
         ctrl_q.wipe_go    <= wctl.wipe_go && wctl.wipe_allow && wipe_arm_q;
         ctrl_q.program_go <= wctl.program_go && wctl.program_allow
                              && prog_arm_q;
         // read allow must already be set before the go write
         ctrl_q.read_go    <= wctl.read_go && wctl.read_allow
                              && ctrl_q.read_allow;
      end else begin
         // writes during a cycle fall through here and are dropped
         if (rd_end) begin
            ctrl_q.read_go <= 1'b0;
         end
         if (wp_end) begin
            ctrl_q.wipe_go <= 1'b0;
         end
         if (pg_end) begin
            ctrl_q.program_go <= 1'b0;
         end
         if (state_q == ST_WFIN) begin
            ctrl_q.wipe_allow <= 1'b0;
         end
         if (state_q == ST_PFIN) begin
            ctrl_q.program_allow <= 1'b0;
         end
      end
   end

   // allow history for falling-edge detect
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wa_p_q <= 1'b0;
         pa_p_q <= 1'b0;
      end else begin
         wa_p_q <= ctrl_q.wipe_allow;
         pa_p_q <= ctrl_q.program_allow;
      end
   end

   // index registers and in-page stepping
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         addr_q <= '0;
      end else if (wr_lo && !busy) begin
         addr_q[7:0] <= bus.data;
      end else if (wr_hi && !busy) begin
         addr_q[10:8] <= bus.data[2:0];
      end else if (step) begin
         addr_q[3:0] <= nib_nxt;
      end
   end

   // nibble stop marker, reset by a fresh index
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stop_q <= 1'b0;
      end else if ((wr_lo || wr_hi) && !busy) begin
         stop_q <= 1'b0;
      end else if (val_load && addr_q[3:0] == DEE_NIB_LAST) begin
         stop_q <= 1'b1;
      end
   end

   // value register: software data or read result
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         val_q <= DEE_RST_BYTE;
      end else if (wr_val && !busy) begin
         val_q <= bus.data;
      end else if (rd_end) begin
         val_q <= rd_byte;
      end
   end

   // page buffer; one store serves wipe tags and program data alike
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tag_q <= '0;
         for (int i = 0; i < DEE_PAGE; i++) begin
            buf_q[i] <= DEE_RST_BYTE;
         end
      end else if (clr_buf) begin
         tag_q <= '0;
         for (int i = 0; i < DEE_PAGE; i++) begin
            buf_q[i] <= DEE_RST_BYTE;
         end
      end else if (val_load) begin
         tag_q[addr_q[3:0]] <= 1'b1;
         buf_q[addr_q[3:0]] <= bus.data;
      end
   end

   // array update at the end of a timed cycle; no reset, it is storage
   always_ff @(posedge mclk_i) begin
      if (wp_end) begin
         if (!ctrl_q.mode) begin
            mem_q[addr_q] <= 8'h00;
         end else begin
            for (int i = 0; i < DEE_PAGE; i++) begin
               if (tag_q[i]) begin
                  mem_q[{addr_q[10:4], 4'(i)}] <= 8'h00;
               end
            end
         end
      end else if (pg_end) begin
         if (!ctrl_q.mode) begin
            // overwrite is erase plus program in one step
            mem_q[addr_q] <= val_q;
         end else begin
            for (int i = 0; i < DEE_PAGE; i++) begin
               if (tag_q[i]) begin
                  mem_q[{addr_q[10:4], 4'(i)}] <= buf_q[i];
               end
            end
         end
      end
   end

   // done flag and its allow; a set beats a same-cycle clear
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         done_flag_o      <= 1'b0;
         done_irq_allow_o <= 1'b0;
      end else begin
         if (wp_end || pg_end) begin
            done_flag_o <= 1'b1;
         end else if (wr_done && !bus.data[DEE_DONE_FLAG_BIT]) begin
            done_flag_o <= 1'b0;
         end
         if (wr_done) begin
            done_irq_allow_o <= bus.data[DEE_DONE_ALLOW_BIT];
         end
      end
   end

   // read port: data valid in the cycle after the strobe only
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= 8'h00;
      end else if (!bus.rd) begin
         rdata_o <= 8'h00;
      end else if (bus.addr == DEE_OFF_LO) begin
         rdata_o <= addr_q[7:0];
      end else if (bus.addr == DEE_OFF_HI) begin
         rdata_o <= {5'h00, addr_q[10:8]};
      end else if (bus.addr == DEE_OFF_VAL) begin
         rdata_o <= val_q;
      end else if (bus.addr == DEE_OFF_CTL) begin
         rdata_o <= ctrl_q;
      end else if (bus.addr == DEE_OFF_DONE) begin
         rdata_o <= {6'h00, done_irq_allow_o, done_flag_o};
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_wipe_end;
      state_q == ST_WIPE && cnt_q == '0;
   endsequence
   sequence s_wipe_drop;
      !ctrl_q.wipe_go && ctrl_q.wipe_allow ##1 !ctrl_q.wipe_allow;
   endsequence
   sequence s_prog_end;
      state_q == ST_PROG && cnt_q == '0;
   endsequence
   sequence s_prog_drop;
      !ctrl_q.program_go && ctrl_q.program_allow ##1 !ctrl_q.program_allow;
   endsequence

   chk_read_gate:
   assert property (wr_ctl && !busy && wctl.read_go && !ctrl_q.read_allow
                    |=> !ctrl_q.read_go && state_q == ST_IDLE)
      else $error("read go taken without read allow");

   chk_read_data:
   assert property (rd_end |=> val_q == $past(rd_byte) && !ctrl_q.read_go)
      else $error("read end did not load byte or clear go");

   chk_read_step:
   assert property (rd_end && ctrl_q.mode && addr_q[3:0] != DEE_NIB_LAST
                    |=> addr_q[3:0] == $past(addr_q[3:0]) + 4'h1)
      else $error("page read did not step the nibble");

   chk_nib_sat:
   assert property (step && addr_q[3:0] == DEE_NIB_LAST
                    |=> addr_q[3:0] == DEE_NIB_LAST)
      else $error("nibble rolled over");

   chk_page_fixed:
   assert property (!((wr_lo || wr_hi) && !busy) |=> $stable(addr_q[10:4]))
      else $error("page bits moved by hardware");

   chk_wipe_seq:
   assert property (s_wipe_end |=> s_wipe_drop)
      else $error("wipe end order wrong");

   chk_prog_seq:
   assert property (s_prog_end |=> s_prog_drop)
      else $error("program end order wrong");

   chk_prog_gate:
   assert property (wr_ctl && !busy && wctl.program_go && !prog_arm_q
                    |=> !ctrl_q.program_go ##1 state_q != ST_PROG)
      else $error("program started without arming");

   chk_buf_clear:
   assert property ($fell(ctrl_q.wipe_allow) || $fell(ctrl_q.program_allow)
                    |=> tag_q == '0)
      else $error("buffer not cleared on allow fall");

   chk_buf_drop:
   assert property (wr_val && !busy && ctrl_q.mode && stop_q
                    |=> $stable(tag_q) && $stable(addr_q[3:0]))
      else $error("write after stop changed buffer");

   chk_done_set:
   assert property (wp_end || pg_end |=> done_flag_o [*2])
      else $error("done flag not set at cycle end");

   chk_wipe_zero:
   assert property (wp_end && !ctrl_q.mode |=> mem_q[$past(addr_q)] == 8'h00)
      else $error("wiped byte not zero");

endmodule

// ### dee_pkg.sv
// shared constants and types for the data eeprom sequencer
package dee_pkg;

   // register offsets on the plain register port
   localparam logic [2:0] DEE_OFF_LO   = 3'h0;
   localparam logic [2:0] DEE_OFF_HI   = 3'h1;
   localparam logic [2:0] DEE_OFF_VAL  = 3'h2;
   localparam logic [2:0] DEE_OFF_CTL  = 3'h3;
   localparam logic [2:0] DEE_OFF_DONE = 3'h4;

   // geometry: 2048 bytes, 7-bit page, 4-bit byte
   localparam int unsigned DEE_AW    = 11;
   localparam int unsigned DEE_DEPTH = 2048;
   localparam int unsigned DEE_PAGE  = 16;
   localparam logic [3:0]  DEE_NIB_LAST = 4'hF;

   // done register field positions
   localparam int unsigned DEE_DONE_FLAG_BIT  = 0;
   localparam int unsigned DEE_DONE_ALLOW_BIT = 1;

   // reset values
   localparam logic [7:0] DEE_RST_BYTE = 8'h00;

   // cycle times, ns as printed, and cycles at the clock rate
   localparam int unsigned DEE_CLK_NS   = 20;
   localparam int unsigned DEE_WIPE0_NS = 3_200_000;
   localparam int unsigned DEE_WIPE1_NS = 3_700_000;
   localparam int unsigned DEE_BYTE0_NS = 5_400_000;
   localparam int unsigned DEE_BYTE1_NS = 6_700_000;
   localparam int unsigned DEE_PAGE0_NS = 2_200_000;
   localparam int unsigned DEE_PAGE1_NS = 3_000_000;
   localparam int unsigned DEE_WIPE0_CYC = (DEE_WIPE0_NS + DEE_CLK_NS - 1) / DEE_CLK_NS;
   localparam int unsigned DEE_WIPE1_CYC = (DEE_WIPE1_NS + DEE_CLK_NS - 1) / DEE_CLK_NS;
   localparam int unsigned DEE_BYTE0_CYC = (DEE_BYTE0_NS + DEE_CLK_NS - 1) / DEE_CLK_NS;
   localparam int unsigned DEE_BYTE1_CYC = (DEE_BYTE1_NS + DEE_CLK_NS - 1) / DEE_CLK_NS;
   localparam int unsigned DEE_PAGE0_CYC = (DEE_PAGE0_NS + DEE_CLK_NS - 1) / DEE_CLK_NS;
   localparam int unsigned DEE_PAGE1_CYC = (DEE_PAGE1_NS + DEE_CLK_NS - 1) / DEE_CLK_NS;
   localparam int unsigned DEE_READ_CYC  = 2;
   localparam int unsigned DEE_CW        = 19;

   // control register, msb first as it sits in the byte
   typedef struct packed {
      logic cts;          // cycle_time_select
      logic wipe_allow;
      logic wipe_go;
      logic mode;         // 0 byte, 1 page
      logic program_allow;
      logic program_go;
      logic read_allow;
      logic read_go;
   } dee_ctrl_t;

   // one register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [7:0] data;
   } dee_bus_t;

   // sequencer states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE = 6'b00_0001,
      ST_READ = 6'b00_0010,
      ST_WIPE = 6'b00_0100,
      ST_PROG = 6'b00_1000,
      ST_WFIN = 6'b01_0000,
      ST_PFIN = 6'b10_0000
   } dee_state_t;

endpackage

// ### data_eeprom_page_access_tb_top.sv
// self-checking bench for the data eeprom sequencer
`timescale 1ns/1ns
module data_eeprom_page_access_tb_top
   import dee_pkg::*;
;
   logic       mclk_i;           // 50 MHz clock
   logic       rst_b_i;          // async reset, low
   logic [2:0] addr_i;           // register offset
   logic [7:0] wdata_i;          // write data
   logic       wr_i;             // write strobe
   logic       rd_i;             // read strobe
   logic [7:0] rdata_o;          // read data, one cycle
   logic       busy_o;           // cycle running
   logic       done_flag_o;      // sticky done
   logic       done_irq_allow_o; // done allow bit
   int         fails;            // mismatches
   int         checked;          // comparisons
   logic [7:0] rd_v;             // last value read

   // short cycle counts keep the run small; the long wipe time keeps its default
   // because no scenario selects the slow cycle time for a wipe
   dee_core #(
      .WIPE0_CYC(8),
      .BYTE0_CYC(8),
      .BYTE1_CYC(8),
      .PAGE0_CYC(8),
      .PAGE1_CYC(8)
   ) dut_u (
      .mclk_i          (mclk_i),
      .rst_b_i         (rst_b_i),
      .addr_i          (addr_i),
      .wdata_i         (wdata_i),
      .wr_i            (wr_i),
      .rd_i            (rd_i),
      .rdata_o         (rdata_o),
      .busy_o          (busy_o),
      .done_flag_o     (done_flag_o),
      .done_irq_allow_o(done_irq_allow_o)
   );

   // free-running clock
   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end

   // single compare point
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   // closing report, also used by timeouts
   task automatic print_verdict();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // one write cycle, then an idle cycle so strobes never re-assert in one step
   task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge mclk_i);
      wr_i    <= 1'b0;
      @(posedge mclk_i);
   endtask

   // read strobe; data sampled in the following cycle only
   task automatic bus_rd(input logic [2:0] a);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge mclk_i);
      rd_i   <= 1'b0;
      #1;
      rd_v = rdata_o;
      @(posedge mclk_i);
   endtask

   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      bus_rd(a);
      check(rd_v, exp);
   endtask

   task automatic set_addr(input logic [7:0] hi, input logic [7:0] lo);
      bus_wr(DEE_OFF_HI, hi);
      bus_wr(DEE_OFF_LO, lo);
   endtask

   // busy level once the launching edge has landed
   task automatic busy_chk(input logic exp);
      #1;
      check({7'h00, busy_o}, {7'h00, exp});
      @(posedge mclk_i);
   endtask

   // bounded wait for the running cycle to end
   task automatic wait_idle();
      int n;
      n = 0;
      #1;
      while (busy_o !== 1'b0) begin
         @(posedge mclk_i);
         #1;
         n++;
         if (n > 100) begin
            fails++;
            print_verdict();
         end
      end
      @(posedge mclk_i);
   endtask

   // 17 page reads from lo on page 0x12; the last one repeats nibble F
   task automatic page_rd(input logic [7:0] lo, input logic z);
      logic [7:0] e;
      set_addr(8'h01, lo);
      bus_wr(DEE_OFF_CTL, 8'h12);
      for (int i = 0; i < 17; i++) begin
         bus_wr(DEE_OFF_CTL, 8'h13);
         wait_idle();
         bus_rd(DEE_OFF_VAL);
         e = z ? 8'h00 : {4'h3, (i > 15) ? 4'hF : i[3:0]};
         check(rd_v, e);
      end
      rd_chk(DEE_OFF_LO, {lo[7:4], 4'hF});
      rd_chk(DEE_OFF_HI, 8'h01);
      rd_chk(DEE_OFF_CTL, 8'h12);
   endtask

   // register and port values after reset, unmapped offset reads zero
   task automatic t_reset();
      for (int a = 0; a < 6; a++) begin
         rd_chk(a[2:0], 8'h00);
      end
      check({5'h00, busy_o, done_flag_o, done_irq_allow_o}, 8'h00);
   endtask

   // byte program, polling, busy lockout, done flag, byte read back
   task automatic t_byte();
      set_addr(8'h01, 8'h25);
      bus_wr(DEE_OFF_VAL, 8'hA5);
      // nothing may slip between allow and go, as with interrupts masked
      bus_wr(DEE_OFF_CTL, 8'h08);
      bus_wr(DEE_OFF_CTL, 8'h0C);
      busy_chk(1'b1);
      rd_chk(DEE_OFF_CTL, 8'h0C);
      bus_wr(DEE_OFF_LO, 8'h77);
      wait_idle();
      rd_chk(DEE_OFF_CTL, 8'h00);
      rd_chk(DEE_OFF_LO, 8'h25);
      rd_chk(DEE_OFF_DONE, 8'h01);
      check({7'h00, done_flag_o}, 8'h01);
      bus_wr(DEE_OFF_DONE, 8'h02);
      rd_chk(DEE_OFF_DONE, 8'h02);
      check({6'h00, done_irq_allow_o, done_flag_o}, 8'h02);
      bus_wr(DEE_OFF_CTL, 8'h02);
      bus_wr(DEE_OFF_CTL, 8'h03);
      wait_idle();
      rd_chk(DEE_OFF_VAL, 8'hA5);
      rd_chk(DEE_OFF_CTL, 8'h02);
   endtask

   // go without allow, and allow not directly before go, start nothing
   task automatic t_refuse();
      logic [7:0] k;
      bus_wr(DEE_OFF_CTL, 8'h00);
      bus_wr(DEE_OFF_CTL, 8'h01);
      busy_chk(1'b0);
      bus_wr(DEE_OFF_CTL, 8'h04);
      busy_chk(1'b0);
      for (int j = 0; j < 2; j++) begin
         k = j ? 8'h08 : 8'h40;
         bus_wr(DEE_OFF_CTL, k);
         bus_wr(DEE_OFF_LO, 8'h25);
         bus_wr(DEE_OFF_CTL, k | (k >> 1));
         busy_chk(1'b0);
         bus_wr(DEE_OFF_CTL, 8'h00);
      end
   endtask

   // page wipe by tagging, then page program with one surplus byte
   task automatic t_page();
      bus_wr(DEE_OFF_CTL, 8'h10);
      set_addr(8'h01, 8'h20);
      for (int i = 0; i < 16; i++) begin
         bus_wr(DEE_OFF_VAL, 8'hFF);
      end
      rd_chk(DEE_OFF_LO, 8'h2F);
      bus_wr(DEE_OFF_CTL, 8'h50);
      bus_wr(DEE_OFF_CTL, 8'h70);
      busy_chk(1'b1);
      wait_idle();
      rd_chk(DEE_OFF_CTL, 8'h10);
      page_rd(8'h20, 1'b1);
      set_addr(8'h01, 8'h20);
      for (int i = 0; i < 16; i++) begin
         bus_wr(DEE_OFF_VAL, {4'h3, i[3:0]});
      end
      bus_wr(DEE_OFF_VAL, 8'hEE);
      // the page was wiped above before it is programmed
      bus_wr(DEE_OFF_CTL, 8'h18);
      bus_wr(DEE_OFF_CTL, 8'h1C);
      busy_chk(1'b1);
      wait_idle();
      rd_chk(DEE_OFF_CTL, 8'h10);
      page_rd(8'h20, 1'b0);
   endtask

   // allow falling empties the buffer, so the cycle then changes nothing
   task automatic t_clear();
      logic [7:0] k;
      for (int j = 0; j < 2; j++) begin
         k = j ? 8'h18 : 8'h50;
         set_addr(8'h01, 8'h20);
         bus_wr(DEE_OFF_VAL, 8'hEE);
         bus_wr(DEE_OFF_CTL, k);
         bus_wr(DEE_OFF_CTL, 8'h10);
         bus_wr(DEE_OFF_CTL, k);
         bus_wr(DEE_OFF_CTL, k | ((k & 8'h48) >> 1));
         wait_idle();
         set_addr(8'h01, 8'h20);
         bus_wr(DEE_OFF_CTL, 8'h12);
         bus_wr(DEE_OFF_CTL, 8'h13);
         wait_idle();
         rd_chk(DEE_OFF_VAL, 8'h30);
      end
   endtask

   // reset, then the scenarios in order
   initial begin
      rst_b_i = 1'b0;
      addr_i  = 3'h0;
      wdata_i = 8'h00;
      wr_i    = 1'b0;
      rd_i    = 1'b0;
      fails   = 0;
      checked = 0;
      repeat (20) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      @(posedge mclk_i);
      t_reset();
      t_byte();
      t_refuse();
      t_page();
      t_clear();
      print_verdict();
   end
endmodule
